// ==== bench/crypto_status_interlock_tb.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %0t: got %h want %h", $time, g, e); end end
module crypto_status_interlock_tb;
    import crypto_status_pkg::*;
    logic clock_in = 0, rst_n_in = 0, s_axi_awvalid_in = 0, s_axi_wvalid_in = 0;
    logic s_axi_bready_in = 0, s_axi_arvalid_in = 0, s_axi_rready_in = 0, engine_active_in = 0;
    logic text_a_in_use_in = 0, op_done_in = 0, ctr_mode_in = 0, counter_wrap_in = 0;
    logic otp_read_in = 0, mode_config_valid_in = 1, key_config_valid_in = 1;
    logic [3:0] s_axi_awaddr_in = 0, s_axi_araddr_in = 0, s_axi_wstrb_in = 4'hf;
    logic [31:0] s_axi_wdata_in = 0, s_axi_rdata_out, d;
    logic [15:0] page_unavailable_in = 0;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    logic s_axi_rvalid_out, operation_go_out, write_start_out, module_on_out;
    logic module_disable_out, irq_out, go, on, dis, abt, wrp;
    logic [3:0] key_page_select_out, pg, irqs;
    int errors = 0, num_checks = 0, cycles = 0, ws_cnt = 0, ws_exp = 0;
    crypto_status_interlock dut (.*);
    always #20 clock_in = ~clock_in;
    // cycle count, start pulses seen and hang limit
    always @(posedge clock_in) begin
        cycles++;
        if (write_start_out === 1'b1) ws_cnt++;
        if (cycles == 6000) begin
            errors++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // expected status word from the current inputs and sticky model bits
    function automatic logic [31:0] stat_exp();
        logic [7:0] s;
        s = {engine_active_in | otp_read_in, text_a_in_use_in, abt, wrp, 1'b0,
             !mode_config_valid_in, !key_config_valid_in | otp_read_in,
             page_unavailable_in[pg] | otp_read_in};
        return {24'h0, dis ? (s & 8'h30) : s};
    endfunction
    // axi4-lite write, both channels offered together
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        logic ta, tw, tb;
        logic [1:0] rsp;
        @(posedge clock_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= v;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        s_axi_bready_in <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge clock_in);
            ta = s_axi_awvalid_in && s_axi_awready_out;
            tw = s_axi_wvalid_in && s_axi_wready_out;
            tb = s_axi_bvalid_out;
            rsp = s_axi_bresp_out;
            @(posedge clock_in);
            if (ta) s_axi_awvalid_in <= 1'b0;
            if (tw) s_axi_wvalid_in <= 1'b0;
        end
        s_axi_bready_in <= 1'b0;
        `CHK(rsp, resp_okay)
    endtask
    // axi4-lite read
    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        logic ta, tr;
        logic [1:0] rsp;
        @(posedge clock_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        tr = 1'b0;
        while (!tr) begin
            @(negedge clock_in);
            ta = s_axi_arvalid_in && s_axi_arready_out;
            tr = s_axi_rvalid_out;
            d = s_axi_rdata_out;
            rsp = s_axi_rresp_out;
            @(posedge clock_in);
            if (ta) s_axi_arvalid_in <= 1'b0;
        end
        s_axi_rready_in <= 1'b0;
        `CHK(d, e)
        `CHK(rsp, resp_okay)
    endtask
    // control write with the model of go, abort, start and refusal events
    task automatic ctl(input logic g, input logic o, input logic ds, input logic w);
        logic [31:0] s;
        logic ok;
        s = stat_exp();
        ok = on && !dis && !abt && !wrp;
        if (w && !dis && s[2:0] == 3'h0) ws_exp++;
        else if (w) irqs[ev_start_refused_bit] = 1'b1;
        if (g && !go && !ok) irqs[ev_go_refused_bit] = 1'b1;
        if (!g && go) begin
            abt = 1'b1;
            irqs[ev_abort_bit] = 1'b1;
        end
        go = g && (go || ok) && !ds;
        if (ds) {abt, wrp} = 2'b00;
        wr(control_offset, {20'h0, pg, 4'h0, ds, o, w, g});
        on = o;
        dis = ds;
        @(negedge clock_in);
    endtask
    // v is {otp, key ok, mode ok, text a busy, engine active, ctr}
    task automatic setin(input logic [5:0] v, input logic [15:0] u);
        @(posedge clock_in);
        {otp_read_in, key_config_valid_in, mode_config_valid_in, text_a_in_use_in,
         engine_active_in, ctr_mode_in} <= v;
        page_unavailable_in <= u;
        repeat (3) @(negedge clock_in);
    endtask
    // one-cycle wrap or done pulse
    task automatic pulse(input logic w);
        @(posedge clock_in);
        if (w) counter_wrap_in <= 1'b1;
        else op_done_in <= 1'b1;
        @(posedge clock_in);
        counter_wrap_in <= 1'b0;
        op_done_in <= 1'b0;
        if (w && go && ctr_mode_in) {wrp, irqs[ev_wrap_bit]} = 2'b11;
        if (!w) go = 1'b0;
    endtask
    initial begin
        void'($urandom(32'h2abb112e));
        {go, on, dis, abt, wrp, irqs} = 9'h0;
        pg = key_page_reset;
        repeat (12) @(posedge clock_in);
        rst_n_in <= 1'b1;
        repeat (2) @(negedge clock_in);
        rchk(status_offset, 32'h0);
        rchk(control_offset, 32'h0);
        rchk(irq_mask_offset, {28'h0, irq_mask_reset});
        $display("test reset done");
        // random engine and config inputs, module off
        for (int i = 0; i < 12; i++) begin
            pg = 4'($urandom);
            ctl(1'b0, 1'b0, 1'b0, 1'b0);
            setin(6'($urandom) & 6'h3e, 16'($urandom));
            rchk(status_offset, stat_exp());
            rchk(control_offset, {20'h0, pg, 8'h00});
            `CHK(key_page_select_out, pg)
        end
        $display("test flags done");
        // write-start under otp, page, key, mode fault, then clean
        for (int k = 4; k >= 0; k--) begin
            setin(k == 4 ? 6'h38 : k == 2 ? 6'h08 : k == 1 ? 6'h10 : 6'h18,
                k == 3 ? 16'hffff : 16'h0);
            ctl(1'b0, 1'b0, 1'b0, 1'b1);
            `CHK(ws_cnt, ws_exp)
        end
        $display("test start done");
        // go needs the module on; early clear aborts and blocks restart
        ctl(1'b1, 1'b0, 1'b0, 1'b0);
        ctl(1'b0, 1'b1, 1'b0, 1'b0);
        ctl(1'b1, 1'b1, 1'b0, 1'b0);
        `CHK(operation_go_out, 1'b1)
        `CHK(module_on_out, 1'b1)
        setin(6'h1a, 16'h0);
        ctl(1'b0, 1'b1, 1'b0, 1'b0);
        rchk(status_offset, stat_exp());
        ctl(1'b1, 1'b1, 1'b0, 1'b0);
        `CHK(operation_go_out, go)
        wr(status_offset, 32'hff);
        rchk(status_offset, stat_exp());
        wr(status_offset, 32'h0);
        abt = 1'b0;
        rchk(status_offset, stat_exp());
        $display("test abort done");
        // ctr rollover holds off go until cleared
        setin(6'h19, 16'h0);
        ctl(1'b1, 1'b1, 1'b0, 1'b0);
        pulse(1'b1);
        pulse(1'b0);
        rchk(status_offset, stat_exp());
        ctl(1'b1, 1'b1, 1'b0, 1'b0);
        `CHK(operation_go_out, go)
        wr(status_offset, 32'hef);
        wrp = 1'b0;
        ctl(1'b1, 1'b1, 1'b0, 1'b0);
        `CHK(operation_go_out, go)
        pulse(1'b0);
        $display("test wrap done");
        // sticky events, masked then enabled, cleared by writing ones
        rchk(irq_status_offset, {28'h0, irqs});
        `CHK(irq_out, 1'b0)
        wr(irq_mask_offset, 32'hf);
        @(negedge clock_in);
        `CHK(irq_out, |irqs)
        wr(irq_status_offset, {28'h0, irqs});
        irqs = 4'h0;
        @(negedge clock_in);
        `CHK(irq_out, 1'b0)
        $display("test irq done");
        // disable clears flags and blocks go and write-start
        ctl(1'b1, 1'b1, 1'b0, 1'b0);
        ctl(1'b0, 1'b1, 1'b0, 1'b0);
        setin(6'h06, 16'hffff);
        ctl(1'b0, 1'b1, 1'b1, 1'b0);
        rchk(status_offset, stat_exp());
        ctl(1'b1, 1'b1, 1'b1, 1'b1);
        `CHK(ws_cnt, ws_exp)
        `CHK(operation_go_out, 1'b0)
        `CHK(module_disable_out, 1'b1)
        $display("test disable done");
        print_verdict();
    end
endmodule

// ==== bench/crypto_status_monitor.sv ====
`timescale 1ns/1ps
module crypto_status_monitor (
    input wire logic clock_in, // clock
    input wire logic rst_n_in, // reset
    input wire logic [3:0] s_axi_araddr_in, // read address
    input wire logic s_axi_arvalid_in, // ar valid
    input wire logic s_axi_arready_out, // ar ready
    input wire logic [31:0] s_axi_rdata_out, // read data
    input wire logic s_axi_rvalid_out, // r valid
    input wire logic s_axi_rready_in, // r ready
    input wire logic mode_config_valid_in, // mode legal
    input wire logic key_config_valid_in, // key legal
    input wire logic otp_read_in, // otp read
    input wire logic op_done_in, // normal end
    input wire logic operation_go_out, // go
    input wire logic write_start_out, // start pulse
    input wire logic module_on_out, // enable
    input wire logic module_disable_out // disable
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    // offset of the read in flight
    logic [3:0] rd_addr_reg;
    logic [3:0] rd_addr_next;
    always_comb begin
        rd_addr_next = (s_axi_arvalid_in && s_axi_arready_out) ? s_axi_araddr_in : rd_addr_reg;
    end
    always_ff @(posedge clock_in) begin
        rd_addr_reg <= rd_addr_next;
    end
    property p_status_pad;
        s_axi_rvalid_out && rd_addr_reg[3:2] == 2'h0 |-> s_axi_rdata_out[31:8] == 24'h0
            && !s_axi_rdata_out[3];
    endproperty
    a_status_pad: assert property (p_status_pad) else $error("status pad not zero");
    property p_start_config;
        write_start_out |-> $past(mode_config_valid_in, 2) && $past(key_config_valid_in, 2)
            && !$past(otp_read_in, 2);
    endproperty
    a_start_config: assert property (p_start_config) else $error("start bad config");
    property p_start_disable;
        module_disable_out && $past(module_disable_out) |-> !write_start_out;
    endproperty
    a_start_disable: assert property (p_start_disable) else $error("start while off");
    property p_go_disable;
        $past(module_disable_out) |-> !operation_go_out;
    endproperty
    a_go_disable: assert property (p_go_disable) else $error("go while disabled");
    property p_go_done;
        op_done_in && operation_go_out |=> !operation_go_out;
    endproperty
    a_go_done: assert property (p_go_done) else $error("go kept after done");
    property p_go_rise;
        $rose(operation_go_out) |-> $past(module_on_out) && !$past(module_disable_out);
    endproperty
    a_go_rise: assert property (p_go_rise) else $error("go set while off");
    property p_read_stand;
        s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
    endproperty
    a_read_stand: assert property (p_read_stand) else $error("read data dropped");
    property p_read_answer;
        s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    c_start: cover property (write_start_out);
    c_done: cover property (op_done_in && operation_go_out);
    c_off: cover property ($rose(module_disable_out));
endmodule
bind crypto_status_interlock crypto_status_monitor u_monitor (.*);

// ==== logic/crypto_status_interlock.sv ====
`timescale 1ns/1ps
module crypto_status_interlock
    import crypto_status_pkg::*;
(
    input wire logic clock_in, // 25 MHz system clock
    input wire logic rst_n_in, // synchronous reset, active low
    // axi4-lite slave
    input wire logic [3:0] s_axi_awaddr_in, // write address
    input wire logic s_axi_awvalid_in, // write address valid
    output logic s_axi_awready_out, // write address ready
    input wire logic [31:0] s_axi_wdata_in, // write data
    input wire logic [3:0] s_axi_wstrb_in, // byte enables
    input wire logic s_axi_wvalid_in, // write data valid
    output logic s_axi_wready_out, // write data ready
    output logic [1:0] s_axi_bresp_out, // write response
    output logic s_axi_bvalid_out, // write response valid
    input wire logic s_axi_bready_in, // write response ready
    input wire logic [3:0] s_axi_araddr_in, // read address
    input wire logic s_axi_arvalid_in, // read address valid
    output logic s_axi_arready_out, // read address ready
    output logic [31:0] s_axi_rdata_out, // read data
    output logic [1:0] s_axi_rresp_out, // read response
    output logic s_axi_rvalid_out, // read data valid
    input wire logic s_axi_rready_in, // read data ready
    // engine side
    input wire logic engine_active_in, // datapath is running an operation
    input wire logic text_a_in_use_in, // text A register held by datapath
    input wire logic op_done_in, // pulse: operation finished normally
    input wire logic ctr_mode_in, // current operation uses CTR mode
    input wire logic counter_wrap_in, // pulse: text B counter rolled over
    input wire logic mode_config_valid_in, // operating/cipher mode legal
    input wire logic key_config_valid_in, // key/mode combination legal
    input wire logic [15:0] page_unavailable_in, // per page: reserved or locked
    input wire logic otp_read_in, // OTP read sequence in progress
    output logic operation_go_out, // go bit to datapath
    output logic write_start_out, // pulse: accepted write-start
    output logic module_on_out, // module enable
    output logic module_disable_out, // module disable
    output logic [3:0] key_page_select_out, // selected key page
    output logic irq_out // level interrupt
);
    // write and read transaction holding and response state
    logic aw_held_reg, aw_held_next;
    logic w_held_reg, w_held_next;
    logic [3:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    // block state
    logic go_reg, go_next;
    logic on_reg, on_next;
    logic disable_reg, disable_next;
    logic [3:0] page_reg, page_next;
    logic busy_reg, busy_next;
    logic text_a_busy_reg, text_a_busy_next;
    logic abort_reg, abort_next;
    logic wrap_reg, wrap_next;
    logic mode_fail_reg, mode_fail_next;
    logic key_fail_reg, key_fail_next;
    logic page_fail_reg, page_fail_next;
    logic start_reg, start_next;
    logic [event_count-1:0] irq_status_reg, irq_status_next;
    logic [event_count-1:0] irq_mask_reg, irq_mask_next;
    // decoded strobes
    logic do_write, do_read;
    logic wr_status, wr_control, wr_irq_status, wr_irq_mask;
    logic [15:0] status_word;
    logic [event_count-1:0] events;

    // true when the offset names one of the four registers
    function automatic logic offset_mapped(input logic [3:0] addr);
        offset_mapped = (addr == status_offset) || (addr == control_offset) ||
            (addr == irq_status_offset) || (addr == irq_mask_offset);
    endfunction

    // handshake outputs
    assign s_axi_awready_out = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready_out = !w_held_reg && !bvalid_reg;
    assign s_axi_arready_out = !rvalid_reg;
    assign s_axi_bvalid_out = bvalid_reg;
    assign s_axi_bresp_out = bresp_reg;
    assign s_axi_rvalid_out = rvalid_reg;
    assign s_axi_rresp_out = rresp_reg;
    assign s_axi_rdata_out = rdata_reg;

    // a write is performed once both address and data are held
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    assign do_read = s_axi_arvalid_in && !rvalid_reg;
    assign wr_status = do_write && (awaddr_reg == status_offset) && wstrb_reg[0];
    assign wr_control = do_write && (awaddr_reg == control_offset);
    assign wr_irq_status = do_write && (awaddr_reg == irq_status_offset) && wstrb_reg[0];
    assign wr_irq_mask = do_write && (awaddr_reg == irq_mask_offset) && wstrb_reg[0];

    // status image, unused bits tied to zero
    always_comb begin
        status_word = 16'h0000; // [RULE14]
        status_word[busy_bit] = busy_reg;
        status_word[text_a_busy_bit] = text_a_busy_reg;
        status_word[abort_bit] = abort_reg;
        status_word[wrap_bit] = wrap_reg;
        status_word[mode_fail_bit] = mode_fail_reg;
        status_word[key_fail_bit] = key_fail_reg;
        status_word[page_fail_bit] = page_fail_reg;
    end

    // bus channel next state
    always_comb begin
        aw_held_next = aw_held_reg;
        w_held_next = w_held_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held_next = 1'b1;
            awaddr_next = {s_axi_awaddr_in[3:2], 2'b00};
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held_next = 1'b1;
            wdata_next = s_axi_wdata_in;
            wstrb_next = s_axi_wstrb_in;
        end
        if (do_write) begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = offset_mapped(awaddr_reg) ? resp_okay : resp_slverr;
        end else if (bvalid_reg && s_axi_bready_in) begin
            bvalid_next = 1'b0;
        end
        if (do_read) begin
            rvalid_next = 1'b1;
            rresp_next = offset_mapped({s_axi_araddr_in[3:2], 2'b00}) ?
                resp_okay : resp_slverr;
            case ({s_axi_araddr_in[3:2], 2'b00})
                status_offset: rdata_next = {16'h0000, status_word};
                control_offset: rdata_next = {16'h0000, 4'h0, page_reg, 4'h0,
                    disable_reg, on_reg, 1'b0, go_reg};
                irq_status_offset: rdata_next = {28'h0000000, irq_status_reg};
                irq_mask_offset: rdata_next = {28'h0000000, irq_mask_reg};
                default: rdata_next = 32'h00000000;
            endcase
        end else if (rvalid_reg && s_axi_rready_in) begin
            rvalid_next = 1'b0;
        end
    end

    // bus channel registers
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 4'h0;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= resp_okay;
            rvalid_reg <= 1'b0;
            rresp_reg <= resp_okay;
            rdata_reg <= 32'h00000000;
        end else begin
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end

    // control, flags and interrupt next state
    always_comb begin
        logic go_set_req;
        logic go_sw_clear;
        logic go_hw_clear;
        logic start_req;
        logic start_blocked;
        go_set_req = wr_control && wstrb_reg[0] && wdata_reg[go_bit] && !go_reg;
        go_hw_clear = go_reg && op_done_in;
        go_sw_clear = wr_control && wstrb_reg[0] && !wdata_reg[go_bit] && go_reg &&
            !op_done_in;
        start_req = wr_control && wstrb_reg[0] && wdata_reg[write_start_bit];
        start_blocked = mode_fail_reg || key_fail_reg || page_fail_reg ||
            disable_reg; // [RULE6] [RULE7] [RULE8]
        events = '0;
        // configuration fields
        on_next = on_reg;
        disable_next = disable_reg;
        page_next = page_reg;
        if (wr_control && wstrb_reg[0]) begin
            on_next = wdata_reg[module_on_bit];
            disable_next = wdata_reg[module_disable_bit];
        end
        if (wr_control && wstrb_reg[1]) begin
            page_next = wdata_reg[page_lsb +: page_width];
        end
        // go: hardware completion and software clear win over a start
        go_next = go_reg;
        if (disable_reg) begin
            go_next = 1'b0;
        end else if (go_hw_clear || go_sw_clear) begin
            go_next = 1'b0;
        end else if (go_set_req) begin
            if (on_reg && !wrap_reg && !abort_reg) begin // [RULE5] [RULE13]
                go_next = 1'b1;
            end else begin
                events[ev_go_refused_bit] = 1'b1;
            end
        end
        // write-start is a one-cycle pulse when no fail flag stands and disable is clear
        start_next = 1'b0;
        if (start_req) begin
            if (start_blocked) begin
                events[ev_start_refused_bit] = 1'b1;
            end else begin
                start_next = 1'b1;
            end
        end
        // live flags: disable clears, OTP read forces busy, key and page fail, else follow inputs
        busy_next = !disable_reg && (otp_read_in || engine_active_in); // [RULE1] [RULE9] [RULE12]
        text_a_busy_next = !disable_reg && text_a_in_use_in; // [RULE2] [RULE9]
        mode_fail_next = !disable_reg && !mode_config_valid_in; // [RULE6] [RULE11]
        key_fail_next = !disable_reg && (otp_read_in || !key_config_valid_in); // [RULE7] [RULE12]
        page_fail_next = !disable_reg &&
            (otp_read_in || page_unavailable_in[page_reg]); // [RULE8] [RULE11] [RULE12]
        // sticky flags: hardware set beats software clear
        abort_next = abort_reg;
        wrap_next = wrap_reg;
        if (wr_status && !wdata_reg[abort_bit]) begin
            abort_next = 1'b0; // [RULE15]
        end
        if (wr_status && !wdata_reg[wrap_bit]) begin
            wrap_next = 1'b0; // [RULE15]
        end
        if (!disable_reg && go_sw_clear) begin
            abort_next = 1'b1; // [RULE3]
            events[ev_abort_bit] = !abort_reg;
        end
        if (!disable_reg && go_reg && ctr_mode_in && counter_wrap_in) begin
            wrap_next = 1'b1; // [RULE4]
            events[ev_wrap_bit] = !wrap_reg;
        end
        if (disable_reg) begin
            abort_next = 1'b0; // [RULE10]
            wrap_next = 1'b0; // [RULE10]
        end
        // interrupt status: write one clears, a new event wins
        irq_status_next = irq_status_reg;
        if (wr_irq_status) begin
            irq_status_next = irq_status_reg & ~wdata_reg[event_count-1:0];
        end
        irq_status_next = irq_status_next | events;
        irq_mask_next = irq_mask_reg;
        if (wr_irq_mask) begin
            irq_mask_next = wdata_reg[event_count-1:0];
        end
    end

    // control, flags and interrupt registers
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            go_reg <= 1'b0;
            on_reg <= 1'b0;
            disable_reg <= 1'b0;
            page_reg <= key_page_reset;
            busy_reg <= 1'b0; // [RULE9]
            text_a_busy_reg <= 1'b0;
            abort_reg <= 1'b0; // [RULE10]
            wrap_reg <= 1'b0;
            mode_fail_reg <= 1'b0;
            key_fail_reg <= 1'b0;
            page_fail_reg <= 1'b0;
            start_reg <= 1'b0;
            irq_status_reg <= '0;
            irq_mask_reg <= irq_mask_reset;
        end else begin
            go_reg <= go_next;
            on_reg <= on_next;
            disable_reg <= disable_next;
            page_reg <= page_next;
            busy_reg <= busy_next;
            text_a_busy_reg <= text_a_busy_next;
            abort_reg <= abort_next;
            wrap_reg <= wrap_next;
            mode_fail_reg <= mode_fail_next;
            key_fail_reg <= key_fail_next;
            page_fail_reg <= page_fail_next;
            start_reg <= start_next;
            irq_status_reg <= irq_status_next;
            irq_mask_reg <= irq_mask_next;
        end
    end

    // outputs to the datapath
    assign operation_go_out = go_reg;
    assign write_start_out = start_reg;
    assign module_on_out = on_reg;
    assign module_disable_out = disable_reg;
    assign key_page_select_out = page_reg;
    assign irq_out = |(irq_status_reg & irq_mask_reg);
endmodule

// ==== pkg/crypto_status_pkg.sv ====
// Overview of operation
// RULE1 - busy flag high during any operation
// RULE2 - text A busy while register in use
// RULE3 - abort set when software clears go early
// RULE4 - wrap flag set on CTR counter rollover
// RULE5 - go refused while wrap flag set
// RULE6 - bad mode raises flag, blocks write-start
// RULE7 - bad key config raises flag, blocks write-start
// RULE8 - reserved or locked page blocks write-start
// RULE9 - reset or disable clears five live flags
// RULE10 - reset or disable clears abort and wrap
// RULE11 - config flags evaluated while module off
// RULE12 - OTP read forces busy, key, page high
// RULE13 - no operation starts while abort set
// RULE14 - upper byte and bit 3 read zero
// RULE15 - abort and wrap cleared by writing zero
package crypto_status_pkg;
    // register byte offsets
    localparam logic [3:0] status_offset = 4'h0;
    localparam logic [3:0] control_offset = 4'h4;
    localparam logic [3:0] irq_status_offset = 4'h8;
    localparam logic [3:0] irq_mask_offset = 4'hc;
    // status field positions
    localparam int busy_bit = 7;
    localparam int text_a_busy_bit = 6;
    localparam int abort_bit = 5;
    localparam int wrap_bit = 4;
    localparam int mode_fail_bit = 2;
    localparam int key_fail_bit = 1;
    localparam int page_fail_bit = 0;
    // control field positions
    localparam int go_bit = 0;
    localparam int write_start_bit = 1;
    localparam int module_on_bit = 2;
    localparam int module_disable_bit = 3;
    localparam int page_lsb = 8;
    localparam int page_width = 4;
    // interrupt event positions
    localparam int ev_abort_bit = 0;
    localparam int ev_wrap_bit = 1;
    localparam int ev_start_refused_bit = 2;
    localparam int ev_go_refused_bit = 3;
    localparam int event_count = 4;
    // values after reset
    localparam logic [3:0] key_page_reset = 4'h0;
    localparam logic [3:0] irq_mask_reset = 4'h0;
    // axi responses
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
endpackage
